// file: design/rss_datapath.sv
/*
  Datapath for rotate right through carry into the accumulator, subtract
  with borrow (three forms) and decrement with skip on zero (two forms).
  Holds the accumulator and status flags. Assumes the decoder presents one
  operation per cycle with the addressed memory byte already read, and that
  the sequencer honours the skip and dummy outputs.
*/
`timescale 1ns/1ps
`include "rss_defines.svh"

// Function
// - Rotate right through carry: memory byte bits shift down into acc, old carry to bit 7.
// - The rotate writes only the accumulator and carry; memory untouched.
// - Subtract with borrow from memory: acc minus byte minus inverted carry.
// - Immediate form subtracts the immediate byte and inverted carry.
// - After subtraction carry is 0 when negative, 1 when zero or positive.
// - Every subtraction updates wrap, zero, aux, carry, signed and chained zero.
// - Subtract-to-memory writes the difference to memory, not the accumulator.
// - Decrement memory byte, write it back, skip next instruction when zero.
// - A taken skip inserts one dummy cycle while the next is fetched.
// - Decrement-to-acc puts byte minus one in acc, memory kept, skip on zero.
// - When the decremented result is nonzero no skip happens.
module rss_datapath (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_valid,
  input  wire rss_pkg::rss_op_type i_op,
  input  wire logic        [7:0] i_mem_data,
  input  wire logic        [7:0] i_imm,
  output logic             [7:0] o_acc,
  output logic                   o_carry,
  output logic                   o_zero,
  output logic                   o_aux,
  output logic                   o_wrap,
  output logic                   o_sgn,
  output logic                   o_czero,
  output logic                   o_mem_we,
  output logic             [7:0] o_mem_wdata,
  output logic                   o_skip,
  output logic                   o_dummy,
  output logic                   o_done
);
  import rss_pkg::*;

  // Decrement is shared by both skip forms
  function automatic logic [7:0] dec8(input logic [7:0] v);
    dec8 = v - 8'h01;
  endfunction

  rss_state_type state;
  rss_state_type next_state;
  logic [7:0]    acc;
  logic [7:0]    next_acc;
  logic          carry, zero, aux, wrap, sgn, czero;
  logic          next_carry, next_zero, next_aux, next_wrap, next_sgn, next_czero;
  logic          mem_we, next_mem_we;
  logic [7:0]    mem_wdata, next_mem_wdata;
  logic          skip, next_skip;
  logic          dummy, next_dummy;
  logic          done, next_done;
  logic          take;
  logic [7:0]    sub_rhs;
  logic [7:0]    sub_diff;
  logic          sub_carry, sub_aux, sub_wrap, sub_zero;
  logic [7:0]    dec_val;

  // Immediate form swaps in the instruction byte
  assign sub_rhs = (i_op == RSS_OP_SUB_IMM) ? i_imm : i_mem_data;
  assign dec_val = dec8(i_mem_data);
  // Requests arriving during the dummy cycle are ignored
  assign take    = i_valid && (state == RSS_ST_RUN);

  rss_sub8 u_sub (
    .i_min   (acc),
    .i_sub   (sub_rhs),
    .i_carry (carry),
    .o_diff  (sub_diff),
    .o_carry (sub_carry),
    .o_aux   (sub_aux),
    .o_wrap  (sub_wrap),
    .o_zero  (sub_zero)
  );

  // Next state of accumulator, flags, memory write and sequencing
  always_comb begin
    next_state     = RSS_ST_RUN;
    next_acc       = acc;
    next_carry     = carry;
    next_zero      = zero;
    next_aux       = aux;
    next_wrap      = wrap;
    next_sgn       = sgn;
    next_czero     = czero;
    next_mem_we    = 1'b0;
    next_mem_wdata = mem_wdata;
    next_skip      = 1'b0;
    next_dummy     = (state == RSS_ST_DUMMY);
    next_done      = 1'b0;
    if (take) begin
      next_done = 1'b1;
      unique case (i_op)
        RSS_OP_LOAD: begin
          next_acc   = i_mem_data;
          next_carry = i_imm[0];
        end
        RSS_OP_ROT_ACC: begin
          next_acc   = {carry, i_mem_data[7:1]};
          next_carry = i_mem_data[0];
        end
        RSS_OP_SUB_MEM, RSS_OP_SUB_IMM, RSS_OP_SUB_TO_MEM: begin
          // All three forms share one flag update
          next_carry = sub_carry;
          next_zero  = sub_zero;
          next_aux   = sub_aux;
          next_wrap  = sub_wrap;
          next_sgn   = sub_wrap ^ sub_diff[`RSS_MSB];
          next_czero = sub_zero & zero;
          if (i_op == RSS_OP_SUB_TO_MEM) begin
            next_mem_we    = 1'b1;
            next_mem_wdata = sub_diff;
          end else begin
            next_acc = sub_diff;
          end
        end
        RSS_OP_DEC_SKIP: begin
          next_mem_we    = 1'b1;
          next_mem_wdata = dec_val;
          next_skip      = (dec_val == 8'h00);
        end
        RSS_OP_DEC_ACC_SKIP: begin
          next_acc  = dec_val;
          next_skip = (dec_val == 8'h00);
        end
        default: next_done = 1'b0;
      endcase
      // Fetch of the skipped slot is covered by one dummy cycle
      if (next_skip) begin
        next_state = RSS_ST_DUMMY;
      end
    end
  end

  // Register stage; every output comes straight from here
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state     <= RSS_ST_RUN;
      acc       <= `RSS_ACC_RST;
      carry     <= `RSS_FLAG_RST;
      zero      <= `RSS_FLAG_RST;
      aux       <= `RSS_FLAG_RST;
      wrap      <= `RSS_FLAG_RST;
      sgn       <= `RSS_FLAG_RST;
      czero     <= `RSS_FLAG_RST;
      mem_we    <= 1'b0;
      mem_wdata <= 8'h00;
      skip      <= 1'b0;
      dummy     <= 1'b0;
      done      <= 1'b0;
    end else begin
      state     <= next_state;
      acc       <= next_acc;
      carry     <= next_carry;
      zero      <= next_zero;
      aux       <= next_aux;
      wrap      <= next_wrap;
      sgn       <= next_sgn;
      czero     <= next_czero;
      mem_we    <= next_mem_we;
      mem_wdata <= next_mem_wdata;
      skip      <= next_skip;
      dummy     <= next_dummy;
      done      <= next_done;
    end
  end

  assign o_acc       = acc;
  assign o_carry     = carry;
  assign o_zero      = zero;
  assign o_aux       = aux;
  assign o_wrap      = wrap;
  assign o_sgn       = sgn;
  assign o_czero     = czero;
  assign o_mem_we    = mem_we;
  assign o_mem_wdata = mem_wdata;
  assign o_skip      = skip;
  assign o_dummy     = dummy;
  assign o_done      = done;

  // Checks; a taken request is one accepted in the run state
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  sequence rot_req_s;
    i_valid && (state == RSS_ST_RUN) && (i_op == RSS_OP_ROT_ACC);
  endsequence
  sequence sub_req_s;
    i_valid && (state == RSS_ST_RUN)
      && (i_op inside {RSS_OP_SUB_MEM, RSS_OP_SUB_IMM, RSS_OP_SUB_TO_MEM});
  endsequence
  sequence dec_req_s;
    i_valid && (state == RSS_ST_RUN)
      && (i_op inside {RSS_OP_DEC_SKIP, RSS_OP_DEC_ACC_SKIP});
  endsequence
  sequence skip_then_dummy_s;
    o_skip && !o_dummy ##1 o_dummy && !o_skip ##1 !o_dummy;
  endsequence

  rotate_value_a: assert property (rot_req_s |=>
    o_acc == {$past(o_carry), $past(i_mem_data[7:1])} && o_carry == $past(i_mem_data[0]))
    else $error("rotate result wrong");

  rotate_no_mem_a: assert property (rot_req_s |=> !o_mem_we && $stable(o_zero))
    else $error("rotate touched memory or other flags");

  sub_acc_value_a: assert property ((sub_req_s and (i_op != RSS_OP_SUB_TO_MEM)) |=>
    o_acc == 8'($past(o_acc) - $past(sub_rhs) - 8'(!$past(o_carry))) && !o_mem_we)
    else $error("subtract to accumulator wrong");

  // Judged on the result, so a wrong operand select shows here
  sub_imm_operand_a: assert property ((sub_req_s and (i_op == RSS_OP_SUB_IMM)) |=>
    o_acc == 8'($past(o_acc) - $past(i_imm) - 8'(!$past(o_carry))))
    else $error("immediate operand not selected");

  sub_carry_flag_a: assert property (sub_req_s |=> o_carry ==
    ({1'b0, $past(o_acc)} >= 9'({1'b0, $past(sub_rhs)} + 9'(!$past(o_carry)))))
    else $error("borrow carry wrong");

  sub_flags_a: assert property (sub_req_s |=>
    o_zero == ((o_mem_we ? o_mem_wdata : o_acc) == 8'h00)
    && o_sgn == (o_wrap ^ (o_mem_we ? o_mem_wdata[7] : o_acc[7])))
    else $error("subtract flags wrong");

  sub_to_mem_a: assert property ((sub_req_s and (i_op == RSS_OP_SUB_TO_MEM)) |=>
    o_mem_we && $stable(o_acc)
    && o_mem_wdata == 8'($past(o_acc) - $past(i_mem_data) - 8'(!$past(o_carry))))
    else $error("subtract to memory wrong");

  dec_mem_write_a: assert property ((dec_req_s and (i_op == RSS_OP_DEC_SKIP)) |=>
    o_mem_we && o_mem_wdata == 8'($past(i_mem_data) - 8'h01))
    else $error("decrement write-back wrong");

  dec_skip_seq_a: assert property ((dec_req_s and (i_mem_data == 8'h01)) |=>
    skip_then_dummy_s)
    else $error("taken skip lacks one dummy cycle");

  dec_acc_value_a: assert property ((dec_req_s and (i_op == RSS_OP_DEC_ACC_SKIP)) |=>
    !o_mem_we && o_acc == 8'($past(i_mem_data) - 8'h01))
    else $error("decrement to accumulator wrong");

  dec_no_skip_a: assert property ((dec_req_s and (i_mem_data != 8'h01)) |=>
    !o_skip ##1 !o_dummy)
    else $error("skip taken on nonzero result");

  sub_wrap_flag_a: assert property (sub_req_s |=> o_wrap ==
    (($past(o_acc[7]) != $past(sub_rhs[7]))
     && ((o_mem_we ? o_mem_wdata[7] : o_acc[7]) != $past(o_acc[7]))))
    else $error("signed overflow flag wrong");

endmodule // rss_datapath

// file: include/rss_defines.svh
/*
  Constants for the rotate, subtract and decrement-skip datapath:
  reset values of the accumulator and status flags, and the length of the
  dummy cycle. Assumes it is included by its bare name from the design files.
*/
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH

// Reset values of the accumulator and flags
`define RSS_ACC_RST      8'h00
`define RSS_FLAG_RST     1'b0

// Dummy cycles inserted after a taken skip
`define RSS_DUMMY_CYCLES 1

// Bit positions used by the flag logic
`define RSS_MSB          7
`define RSS_NIB_MSB      3

`endif

// file: include/rss_pkg.sv
/*
  Types shared by the datapath: the operation code driven by the decoder
  and the sequencing states. Assumes the decoder uses these same codes.
*/
package rss_pkg;

  // Operation requested by the decoder
  typedef enum logic [2:0] {
    RSS_OP_LOAD,
    RSS_OP_ROT_ACC,
    RSS_OP_SUB_MEM,
    RSS_OP_SUB_IMM,
    RSS_OP_SUB_TO_MEM,
    RSS_OP_DEC_SKIP,
    RSS_OP_DEC_ACC_SKIP
  } rss_op_type;

  // Sequencing: normal issue or inserted dummy cycle
  typedef enum logic {
    RSS_ST_RUN,
    RSS_ST_DUMMY
  } rss_state_type;

endpackage

// file: design/rss_sub8.sv
/*
  Eight-bit subtract with borrow and its flag terms, purely combinational.
  Assumes the caller registers the results; carry in is an inverted borrow.
*/
`timescale 1ns/1ps
`include "rss_defines.svh"

module rss_sub8 (
  input  wire logic [7:0] i_min,
  input  wire logic [7:0] i_sub,
  input  wire logic       i_carry,
  output logic      [7:0] o_diff,
  output logic            o_carry,
  output logic            o_aux,
  output logic            o_wrap,
  output logic            o_zero
);

  logic [8:0] wide;
  logic [4:0] low;
  logic       borrow_in;

  // Borrow is the complement of carry, so carry stays an inverted borrow
  always_comb begin
    borrow_in = ~i_carry;
    wide      = {1'b0, i_min} - {1'b0, i_sub} - {8'h00, borrow_in};
    low       = {1'b0, i_min[`RSS_NIB_MSB:0]} - {1'b0, i_sub[`RSS_NIB_MSB:0]}
                - {4'h0, borrow_in};
    o_diff    = wide[7:0];
    o_carry   = ~wide[8];
    o_aux     = ~low[4];
    o_wrap    = (i_min[`RSS_MSB] != i_sub[`RSS_MSB])
                && (wide[`RSS_MSB] != i_min[`RSS_MSB]);
    o_zero    = (wide[7:0] == 8'h00);
  end

endmodule // rss_sub8

// file: sim/tb.sv
/*
  Self-checking bench for the rotate, subtract and decrement-skip datapath.
  Assumes rss_pkg is compiled first and that the design's own assertions
  watch the port timing; this bench judges values cycle by cycle.
*/
`timescale 1ns/1ps

module tb;
  import rss_pkg::*;

  logic             i_ref_clk;
  logic             i_rst_b;
  logic             i_valid;
  rss_op_type       i_op;
  logic       [7:0] i_mem_data;
  logic       [7:0] i_imm;
  logic       [7:0] o_acc;
  logic             o_carry;
  logic             o_zero;
  logic             o_aux;
  logic             o_wrap;
  logic             o_sgn;
  logic             o_czero;
  logic             o_mem_we;
  logic       [7:0] o_mem_wdata;
  logic             o_skip;
  logic             o_dummy;
  logic             o_done;
  int               errors;
  int               n_compared;
  int               cycles;
  logic             model_zero;

  rss_datapath rss_datapath_inst (
    .i_ref_clk  (i_ref_clk),
    .i_rst_b    (i_rst_b),
    .i_valid    (i_valid),
    .i_op       (i_op),
    .i_mem_data (i_mem_data),
    .i_imm      (i_imm),
    .o_acc      (o_acc),
    .o_carry    (o_carry),
    .o_zero     (o_zero),
    .o_aux      (o_aux),
    .o_wrap     (o_wrap),
    .o_sgn      (o_sgn),
    .o_czero    (o_czero),
    .o_mem_we   (o_mem_we),
    .o_mem_wdata(o_mem_wdata),
    .o_skip     (o_skip),
    .o_dummy    (o_dummy),
    .o_done     (o_done)
  );

  // 20 MHz clock
  initial i_ref_clk = 1'b0;
  always #25 i_ref_clk = ~i_ref_clk;

  // Hang guard, far above the fewer than a hundred cycles the run needs
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One request held for one taking edge; outputs sampled once settled
  task automatic req(input rss_op_type op, input logic [7:0] mem, input logic [7:0] imm);
    @(posedge i_ref_clk);
    i_valid    <= 1'b1;
    i_op       <= op;
    i_mem_data <= mem;
    i_imm      <= imm;
    @(posedge i_ref_clk);
    i_valid    <= 1'b0;
    #1;
    chk({7'h00, o_done}, 8'h01);
  endtask

  // Preset accumulator and carry through the test-only load operation
  task automatic preset(input logic [7:0] a, input logic c);
    req(RSS_OP_LOAD, a, {7'h00, c});
  endtask

  task automatic rot_case(input logic c, input logic [7:0] m);
    preset(8'h5a, c);
    req(RSS_OP_ROT_ACC, m, 8'h00);
    chk(o_acc, {c, m[7:1]});
    chk({7'h00, o_carry}, {7'h00, m[0]});
    chk({7'h00, o_mem_we}, 8'h00);
  endtask

  // Expected difference and flags worked out in nine bits
  task automatic sub_case(input rss_op_type op, input logic [7:0] a, input logic c,
                          input logic [7:0] m);
    logic [8:0] full;
    logic [4:0] nib;
    logic       wrap;
    full = {1'b0, a} - {1'b0, m} - {8'h00, ~c};
    nib  = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
    wrap = (a[7] != m[7]) && (full[7] != a[7]);
    preset(a, c);
    // Immediate form gets a decoy memory byte so a wrong operand shows
    if (op == RSS_OP_SUB_IMM) req(op, ~m, m);
    else req(op, m, ~m);
    if (op == RSS_OP_SUB_TO_MEM) begin
      chk(o_mem_wdata, full[7:0]);
      chk({7'h00, o_mem_we}, 8'h01);
      chk(o_acc, a);
    end else begin
      chk(o_acc, full[7:0]);
      chk({7'h00, o_mem_we}, 8'h00);
    end
    chk({7'h00, o_carry}, {7'h00, ~full[8]});
    chk({7'h00, o_zero}, {7'h00, full[7:0] == 8'h00});
    chk({7'h00, o_aux}, {7'h00, ~nib[4]});
    chk({7'h00, o_wrap}, {7'h00, wrap});
    chk({7'h00, o_sgn}, {7'h00, wrap ^ full[7]});
    // Chained zero needs this and the previous subtraction both zero
    chk({7'h00, o_czero}, {7'h00, (full[7:0] == 8'h00) && model_zero});
    model_zero = (full[7:0] == 8'h00);
  endtask

  task automatic dec_case(input rss_op_type op, input logic [7:0] m);
    logic [7:0] r;
    r = m - 8'h01;
    preset(8'h77, 1'b1);
    req(op, m, 8'h00);
    if (op == RSS_OP_DEC_SKIP) begin
      chk({7'h00, o_mem_we}, 8'h01);
      chk(o_mem_wdata, r);
      chk(o_acc, 8'h77);
    end else begin
      chk({7'h00, o_mem_we}, 8'h00);
      chk(o_acc, r);
    end
    chk({7'h00, o_skip}, {7'h00, r == 8'h00});
    @(posedge i_ref_clk);
    #1;
    chk({7'h00, o_dummy}, {7'h00, r == 8'h00});
  endtask

  // Request kept up over the edge after a taken skip must be dropped
  task automatic skip_swallow();
    preset(8'h3c, 1'b0);
    @(posedge i_ref_clk);
    i_valid    <= 1'b1;
    i_op       <= RSS_OP_DEC_SKIP;
    i_mem_data <= 8'h01;
    @(posedge i_ref_clk);
    i_op       <= RSS_OP_LOAD;
    i_mem_data <= 8'haa;
    #1;
    chk({7'h00, o_skip}, 8'h01);
    chk(o_mem_wdata, 8'h00);
    @(posedge i_ref_clk);
    i_valid <= 1'b0;
    #1;
    chk({7'h00, o_dummy}, 8'h01);
    chk({7'h00, o_done}, 8'h00);
    chk(o_acc, 8'h3c);
  endtask

  // Main sequence
  initial begin
    errors     = 0;
    n_compared = 0;
    cycles     = 0;
    model_zero = 1'b0;
    i_rst_b    = 1'b0;
    i_valid    = 1'b0;
    i_op       = RSS_OP_LOAD;
    i_mem_data = 8'h00;
    i_imm      = 8'h00;
    repeat (6) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    #1;
    chk(o_acc, 8'h00);
    chk({7'h00, o_carry}, 8'h00);
    rot_case(1'b1, 8'h80);
    rot_case(1'b0, 8'h03);
    sub_case(RSS_OP_SUB_MEM, 8'h10, 1'b1, 8'h20);
    sub_case(RSS_OP_SUB_MEM, 8'h05, 1'b0, 8'h04);
    sub_case(RSS_OP_SUB_IMM, 8'h00, 1'b1, 8'h00);
    sub_case(RSS_OP_SUB_MEM, 8'h18, 1'b1, 8'h09);
    sub_case(RSS_OP_SUB_IMM, 8'h80, 1'b1, 8'h01);
    sub_case(RSS_OP_SUB_IMM, 8'h00, 1'b0, 8'hff);
    sub_case(RSS_OP_SUB_TO_MEM, 8'h33, 1'b1, 8'h11);
    sub_case(RSS_OP_SUB_TO_MEM, 8'h7f, 1'b0, 8'h80);
    dec_case(RSS_OP_DEC_SKIP, 8'h01);
    dec_case(RSS_OP_DEC_SKIP, 8'h00);
    dec_case(RSS_OP_DEC_SKIP, 8'h02);
    dec_case(RSS_OP_DEC_ACC_SKIP, 8'h05);
    dec_case(RSS_OP_DEC_ACC_SKIP, 8'h01);
    skip_swallow();
    test_done();
  end
endmodule // tb
